// >>> bench/lpid_host.sv
// Purpose: Host serial master model
// Assumes: Mode 0, 50 ns half period of the serial clock
// Notes:   Frames are started by calling xfer
`timescale 1ns/1ps
module lpid_host (
  input wire logic mclk,
  output logic     spi_sclk,
  output logic     spi_cs_n,
  output logic     spi_mosi,
  input wire logic spi_miso
);
  // ***
  // Frame driver
  // ***
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Address, rw, data, MSB first; clock still outside frames
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    spi_cs_n = 1'b0;
    tick(5);
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = w[i];
      tick(5);
      spi_sclk = 1'b1;
      r = {r[30:0], spi_miso};
      tick(5);
      spi_sclk = 1'b0;
    end
    spi_mosi = ~spi_mosi;
    tick(2);
    spi_cs_n = 1'b1;
    tick(8);
  endtask
endmodule

// >>> bench/lpid_top_asserts.sv
// Purpose: Port assertions for lpid_top
// Assumes: One clock domain, rst_n async low
// Notes:   Bound to every lpid_top instance
`timescale 1ns/1ps
module lpid_top_asserts #(
  parameter int GND_CH = 14,
  parameter int PRG_CH = 8
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              spi_cs_n,
  input wire logic              spi_miso_oe,
  input wire logic              low_power_state,
  input wire logic [PRG_CH-1:0] prg_battery_ref,
  input wire logic [GND_CH-1:0] gnd_comp_enable,
  input wire logic [GND_CH-1:0] gnd_poll_enable,
  input wire logic [GND_CH-1:0] gnd_thr_normal,
  input wire logic [PRG_CH-1:0] prg_thr_sel_normal,
  input wire logic [PRG_CH-1:0] prg_thr_fixed4,
  input wire logic              wake_request
);
  // ***
  // Port relations
  // ***
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_lp_on; low_power_state[*4]; endsequence
  sequence s_lp_off; !low_power_state[*5]; endsequence
  sequence s_ref_hold; $stable(prg_battery_ref)[*3]; endsequence
  property p_comp_on; s_lp_on |-> &gnd_comp_enable; endproperty
  a_comp_on: assert property (p_comp_on) else $error("comparators off in low power");
  property p_lp_off; s_lp_off |-> !gnd_comp_enable && !gnd_poll_enable && !wake_request; endproperty
  a_lp_off: assert property (p_lp_off) else $error("sensing active outside low power");
  property p_poll; !(gnd_poll_enable & ~gnd_comp_enable); endproperty
  a_poll: assert property (p_poll) else $error("polling without comparator");
  property p_fixed4; s_ref_hold |-> prg_thr_fixed4 == prg_battery_ref; endproperty
  a_fixed4: assert property (p_fixed4) else $error("fixed threshold mismatch");
  property p_sel; s_ref_hold |-> !(prg_thr_sel_normal & prg_battery_ref); endproperty
  a_sel: assert property (p_sel) else $error("battery channel uses threshold bit");
  property p_thr_hold; spi_cs_n[*8] |-> $stable(gnd_thr_normal); endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold changed without frame");
  property p_oe_idle; spi_cs_n[*4] |-> !spi_miso_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
  property p_oe_busy; !spi_cs_n[*4] |-> spi_miso_oe; endproperty
  a_oe_busy: assert property (p_oe_busy) else $error("output idle while selected");
  property p_wake; wake_request |=> !wake_request; endproperty
  a_wake: assert property (p_wake) else $error("wake request longer than a pulse");
endmodule

bind lpid_top lpid_top_asserts #(.GND_CH(GND_CH), .PRG_CH(PRG_CH)) i_asserts (
  .mclk, .rst_n, .spi_cs_n, .spi_miso_oe, .low_power_state, .prg_battery_ref, .gnd_comp_enable,
  .gnd_poll_enable, .gnd_thr_normal, .prg_thr_sel_normal, .prg_thr_fixed4, .wake_request);

// >>> bench/lpid_top_tb.sv
// Purpose: Self-checking bench for lpid_top
// Assumes: Host model drives the serial port
// Notes:   Replies carry the previous frame's answer
`timescale 1ns/1ps
module lpid_top_tb;
  logic        mclk            = 1'b0;
  logic        rst_n           = 1'b0;
  logic        fault_status    = 1'b0;
  logic        interrupt_flag  = 1'b0;
  logic        low_power_state = 1'b0;
  logic [7:0]  prg_battery_ref = 8'h0f;
  logic [13:0] gnd_wake_en     = 14'h0000;
  logic [7:0]  prg_wake_en     = 8'h00;
  logic [13:0] gnd_comp_in     = 14'h0000;
  logic [7:0]  prg_comp_in     = 8'h00;
  logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, wake_request;
  logic [13:0] gnd_comp_enable, gnd_poll_enable, gnd_thr_normal;
  logic [7:0]  prg_thr_sel_normal, prg_thr_fixed4;
  int          fail_count      = 0;
  int          checked         = 0;
  always #5 mclk = ~mclk;
  lpid_top i_dut (.mclk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .fault_status,
    .interrupt_flag, .low_power_state, .prg_battery_ref, .gnd_wake_en, .prg_wake_en, .gnd_comp_in, .prg_comp_in,
    .gnd_comp_enable, .gnd_poll_enable, .gnd_thr_normal, .prg_thr_sel_normal, .prg_thr_fixed4, .wake_request);
  lpid_host i_host (.mclk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  // ***
  // Shared tasks
  // ***
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [31:0] r;
    i_host.xfer({a, 1'b1, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] r);
    i_host.xfer({a, 1'b0, 24'h0}, r);
    i_host.xfer({a, 1'b0, 24'h0}, r);
  endtask
  task automatic wake_chk(input logic exp);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 12; i++) begin
      i_host.tick(1);
      got |= wake_request;
    end
    chk(32'(got), 32'(exp));
  endtask
  // ***
  // Scenarios
  // ***
  task automatic t_regs(input logic wr_en);
    logic [21:0] msk [4] = '{22'h3fff, 22'h0ff, 22'h3fff, 22'h0};
    logic [6:0]  a;
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      a = 7'h13 + 7'(k);
      if (wr_en) wr(a, 24'hffffff);
      fault_status = k[0];
      interrupt_flag = ~k[0];
      rd(a, r);
      chk(r, {a, 1'b0, k[0], ~k[0], msk[k] & {22{wr_en}}});
    end
  endtask
  task automatic t_thr();
    logic [7:0] bat [2] = '{8'h0f, 8'hf0};
    wr(7'h15, 24'h001a5c);
    wr(7'h14, 24'h0000c3);
    for (int k = 0; k < 2; k++) begin
      prg_battery_ref = bat[k];
      i_host.tick(4);
      chk(32'(gnd_thr_normal), 32'h1a5c);
      chk(32'(prg_thr_sel_normal), 32'(8'hc3 & ~bat[k]));
      chk(32'(prg_thr_fixed4), 32'(bat[k]));
    end
  endtask
  task automatic t_lp();
    wr(7'h13, 24'h000f0f);
    low_power_state = 1'b1;
    i_host.tick(6);
    chk(32'(gnd_comp_enable), 32'h3fff);
    chk(32'(gnd_poll_enable), 32'h30f0);
    gnd_wake_en = 14'h0001;
    gnd_comp_in = 14'h0001;
    wake_chk(1'b1);
    gnd_wake_en = 14'h0000;
    gnd_comp_in = 14'h0000;
    wake_chk(1'b0);
    prg_wake_en = 8'h08;
    prg_comp_in = 8'h08;
    wake_chk(1'b1);
    low_power_state = 1'b0;
    i_host.tick(6);
    prg_comp_in = 8'h00;
    wake_chk(1'b0);
  endtask
  task automatic t_rst();
    rst_n = 1'b0;
    i_host.tick(3);
    chk(32'(gnd_thr_normal), 32'h0);
    chk(32'(prg_thr_sel_normal), 32'h0);
    rst_n = 1'b1;
    i_host.tick(4);
    t_regs(1'b0);
  endtask
  initial begin
    i_host.tick(8);
    rst_n = 1'b1;
    i_host.tick(4);
    t_regs(1'b0);
    t_regs(1'b1);
    t_thr();
    t_lp();
    t_rst();
    end_sim();
  end
endmodule

// >>> logic/lpid_cfg.svh
// Purpose: Constants for the low-power input detect configuration block
// Assumes: 32-bit serial frames, 7-bit address, 24-bit data
// Notes:   Included by the package and the design modules
`ifndef LPID_CFG_SVH
`define LPID_CFG_SVH

`define LPID_FRAME_BITS     32
`define LPID_ADDR_MSB       31
`define LPID_ADDR_LSB       25
`define LPID_RW_BIT         24
`define LPID_DATA_BITS      24
`define LPID_FAULT_BIT      23
`define LPID_INTERRUPT_FLAG_BIT     22

`define LPID_ADDR_GND_CMP   7'h13
`define LPID_ADDR_PRG_THR   7'h14
`define LPID_ADDR_GND_THR   7'h15

`define LPID_GND_CHANNELS   14
`define LPID_PRG_CHANNELS   8

`define LPID_RST_GND_CMP    14'h0000
`define LPID_RST_PRG_THR    8'h00
`define LPID_RST_GND_THR    14'h0000

`endif

// >>> logic/lpid_pkg.sv
// Purpose: Types shared by the low-power input detect configuration block
// Assumes: Constants come from lpid_cfg.svh
// Notes:   Holds the frame field types and sensing threshold encoding
`include "lpid_cfg.svh"

package lpid_pkg;

  typedef logic [6:0]                      lpid_addr_t;
  typedef logic [`LPID_DATA_BITS-1:0]      lpid_data_t;

  // Threshold a channel is judged against in the low-power state
  typedef enum logic [1:0] {
    LPID_THR_DELTA  = 2'b00,
    LPID_THR_NORMAL = 2'b01,
    LPID_THR_FIXED4 = 2'b10
  } lpid_thr_t;

  typedef enum logic [1:0] {
    LPID_SPI_IDLE  = 2'b00,
    LPID_SPI_SHIFT = 2'b01,
    LPID_SPI_DONE  = 2'b10
  } lpid_spi_state_t;

endpackage

// >>> logic/lpid_spi_frame.sv
// Purpose: Serial slave that collects 32-bit frames and shifts out a reply
// Assumes: Mode 0, sampled on rising serial clock, 32 bits per frame
// Notes:   Pins are synchronised into mclk before use
`timescale 1ns/1ps
`include "lpid_cfg.svh"

module lpid_spi_frame (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        spi_sclk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_mosi,
  output logic                             spi_miso,
  output logic                             spi_miso_oe,
  input  wire logic [`LPID_FRAME_BITS-1:0] reply_word,
  output logic                             frame_start,
  output logic                             frame_valid,
  output logic [`LPID_FRAME_BITS-1:0]      frame_word
);

  logic [2:0]                        sclk_sync_q;
  logic [1:0]                        cs_sync_q;
  logic [1:0]                        mosi_sync_q;
  logic                              cs_prev_q;
  logic [5:0]                        bit_cnt_q;
  logic [`LPID_FRAME_BITS-1:0]       shift_in_q;
  logic [`LPID_FRAME_BITS-1:0]       shift_out_q;
  lpid_pkg::lpid_spi_state_t         state_q;
  logic                              sclk_rise;
  logic                              sclk_fall;
  logic                              cs_act;

  // Two-stage synchronisers; edges judged on stages two and three
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_q <= 3'h0;
      cs_sync_q   <= 2'h3;
      mosi_sync_q <= 2'h0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
      cs_sync_q   <= {cs_sync_q[0], spi_cs_n};
      mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
      cs_prev_q   <= cs_sync_q[1];
    end
  end

  assign sclk_rise   = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall   = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_act      = ~cs_sync_q[1];
  assign frame_start = cs_act & cs_prev_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= lpid_pkg::LPID_SPI_IDLE;
      bit_cnt_q   <= 6'h00;
      shift_in_q  <= '0;
      shift_out_q <= '0;
      frame_valid <= 1'b0;
      frame_word  <= '0;
    end else begin
      frame_valid <= 1'b0;
      unique case (state_q)
        lpid_pkg::LPID_SPI_IDLE: begin
          if (frame_start) begin
            shift_out_q <= reply_word;
            bit_cnt_q   <= 6'h00;
            state_q     <= lpid_pkg::LPID_SPI_SHIFT;
          end
        end
        lpid_pkg::LPID_SPI_SHIFT: begin
          if (!cs_act) begin
            state_q <= lpid_pkg::LPID_SPI_IDLE;
          end else if (sclk_rise) begin
            shift_in_q <= {shift_in_q[`LPID_FRAME_BITS-2:0], mosi_sync_q[1]};
            bit_cnt_q  <= bit_cnt_q + 6'h01;
          end else if (sclk_fall) begin
            shift_out_q <= {shift_out_q[`LPID_FRAME_BITS-2:0], 1'b0};
          end
          if (cs_act && bit_cnt_q == 6'h20) begin
            state_q <= lpid_pkg::LPID_SPI_DONE;
          end
        end
        lpid_pkg::LPID_SPI_DONE: begin
          // Frame counts only when exactly 32 bits precede deselect
          if (!cs_act) begin
            frame_valid <= 1'b1;
            frame_word  <= shift_in_q;
            state_q     <= lpid_pkg::LPID_SPI_IDLE;
          end else if (sclk_rise) begin
            state_q <= lpid_pkg::LPID_SPI_IDLE;
          end
        end
        default: state_q <= lpid_pkg::LPID_SPI_IDLE;
      endcase
    end
  end

  assign spi_miso    = shift_out_q[`LPID_FRAME_BITS-1];
  assign spi_miso_oe = cs_act;

endmodule

// >>> logic/lpid_top.sv
// Purpose: Low-power input detect configuration registers and sensing control
// Assumes: Host reaches registers with 32-bit serial frames
// Notes:   Reply of frame N answers frame N-1
`timescale 1ns/1ps
`include "lpid_cfg.svh"

module lpid_top #(
  parameter int GND_CH = `LPID_GND_CHANNELS,
  parameter int PRG_CH = `LPID_PRG_CHANNELS
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe,
  input  wire logic              fault_status,
  input  wire logic              interrupt_flag,
  input  wire logic              low_power_state,
  input  wire logic [PRG_CH-1:0] prg_battery_ref,
  input  wire logic [GND_CH-1:0] gnd_wake_en,
  input  wire logic [PRG_CH-1:0] prg_wake_en,
  input  wire logic [GND_CH-1:0] gnd_comp_in,
  input  wire logic [PRG_CH-1:0] prg_comp_in,
  output logic [GND_CH-1:0]      gnd_comp_enable,
  output logic [GND_CH-1:0]      gnd_poll_enable,
  output logic [GND_CH-1:0]      gnd_thr_normal,
  output logic [PRG_CH-1:0]      prg_thr_sel_normal,
  output logic [PRG_CH-1:0]      prg_thr_fixed4,
  output logic                   wake_request
);

  logic [GND_CH-1:0]                 gnd_cmp_only_q;
  logic [PRG_CH-1:0]                 prg_thr_q;
  logic [GND_CH-1:0]                 gnd_thr_q;
  logic                              frame_start;
  logic                              frame_valid;
  logic [`LPID_FRAME_BITS-1:0]       frame_word;
  logic [`LPID_FRAME_BITS-1:0]       reply_q;
  lpid_pkg::lpid_addr_t              last_addr_q;
  lpid_pkg::lpid_addr_t              frm_addr;
  logic                              frm_write;
  lpid_pkg::lpid_data_t              frm_data;
  lpid_pkg::lpid_data_t              rd_data;
  logic                              wr_gnd_cmp;
  logic                              wr_prg_thr;
  logic                              wr_gnd_thr;
  logic [GND_CH-1:0]                 gnd_s1_q;
  logic [GND_CH-1:0]                 gnd_s2_q;
  logic [GND_CH-1:0]                 gnd_prev_q;
  logic [PRG_CH-1:0]                 prg_s1_q;
  logic [PRG_CH-1:0]                 prg_s2_q;
  logic [PRG_CH-1:0]                 prg_prev_q;
  logic [1:0]                        lp_sync_q;
  logic [GND_CH-1:0]                 gnd_change;
  logic [PRG_CH-1:0]                 prg_change;

  // ****************************************
  // Serial frame engine
  // ****************************************
  lpid_spi_frame u_frame (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .spi_sclk    (spi_sclk),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .reply_word  (reply_q),
    .frame_start (frame_start),
    .frame_valid (frame_valid),
    .frame_word  (frame_word)
  );

  assign frm_addr  = frame_word[`LPID_ADDR_MSB:`LPID_ADDR_LSB];
  assign frm_write = frame_word[`LPID_RW_BIT];
  assign frm_data  = frame_word[`LPID_DATA_BITS-1:0];

  // Register contents for an address, upper bits zero
  function automatic lpid_pkg::lpid_data_t read_reg(input lpid_pkg::lpid_addr_t a);
    lpid_pkg::lpid_data_t r;
    r = '0;
    unique case (a)
      `LPID_ADDR_GND_CMP: r[GND_CH-1:0] = gnd_cmp_only_q;
      `LPID_ADDR_PRG_THR: r[PRG_CH-1:0] = prg_thr_q;
      `LPID_ADDR_GND_THR: r[GND_CH-1:0] = gnd_thr_q;
      default:            r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    rd_data = read_reg(last_addr_q);
  end

  // ****************************************
  // Write decode
  // ****************************************
  // Strobe for a completed write frame to one address
  function automatic logic wr_hit(input logic vld, input logic wr, input lpid_pkg::lpid_addr_t fa,
                                  input lpid_pkg::lpid_addr_t a);
    return vld && wr && (fa == a);
  endfunction

  assign wr_gnd_cmp = wr_hit(frame_valid, frm_write, frm_addr, `LPID_ADDR_GND_CMP);
  assign wr_prg_thr = wr_hit(frame_valid, frm_write, frm_addr, `LPID_ADDR_PRG_THR);
  assign wr_gnd_thr = wr_hit(frame_valid, frm_write, frm_addr, `LPID_ADDR_GND_THR);

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gnd_cmp_only_q <= `LPID_RST_GND_CMP;
    end else if (wr_gnd_cmp) begin
      gnd_cmp_only_q <= frm_data[GND_CH-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prg_thr_q <= `LPID_RST_PRG_THR;
    end else if (wr_prg_thr) begin
      prg_thr_q <= frm_data[PRG_CH-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gnd_thr_q <= `LPID_RST_GND_THR;
    end else if (wr_gnd_thr) begin
      gnd_thr_q <= frm_data[GND_CH-1:0];
    end
  end

  // ****************************************
  // Reply word for next frame
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_addr_q <= 7'h00;
    end else if (frame_valid) begin
      last_addr_q <= frm_addr;
    end
  end

  // Status latched at frame start; data of previously addressed register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reply_q <= '0;
    end else begin
      reply_q <= {last_addr_q, 1'b0, fault_status, interrupt_flag,
                  rd_data[21:0]};
    end
  end

  // ****************************************
  // Sensing control
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lp_sync_q <= 2'h0;
    end else begin
      lp_sync_q <= {lp_sync_q[0], low_power_state};
    end
  end

  assign gnd_comp_enable = {GND_CH{lp_sync_q[1]}};
  assign gnd_poll_enable = {GND_CH{lp_sync_q[1]}} & ~gnd_cmp_only_q;
  assign gnd_thr_normal  = gnd_thr_q;
  assign prg_thr_sel_normal = prg_thr_q & ~prg_battery_ref;
  assign prg_thr_fixed4     = prg_battery_ref;

  // ****************************************
  // Change-of-state wake detection
  // ****************************************
  // Reset level matches idle pin level, so no false edge after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gnd_s1_q   <= '0;
      gnd_s2_q   <= '0;
      gnd_prev_q <= '0;
    end else begin
      gnd_s1_q   <= gnd_comp_in;
      gnd_s2_q   <= gnd_s1_q;
      gnd_prev_q <= gnd_s2_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prg_s1_q   <= '0;
      prg_s2_q   <= '0;
      prg_prev_q <= '0;
    end else begin
      prg_s1_q   <= prg_comp_in;
      prg_s2_q   <= prg_s1_q;
      prg_prev_q <= prg_s2_q;
    end
  end

  assign gnd_change = (gnd_s2_q ^ gnd_prev_q) & gnd_wake_en;
  assign prg_change = (prg_s2_q ^ prg_prev_q) & prg_wake_en;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= lp_sync_q[1] & ((|gnd_change) | (|prg_change));
    end
  end

endmodule
